// file: hdl/athp_port.v
// Task-file host port: pin decode, byte lanes and task-file registers.
// Assumes strobe pins are asynchronous and held several clocks; a
// command engine on mclk_in feeds the data word and completion values.
//
// Contract
// [R01] Data register is a 16-bit word; other task registers are bytes.
// [R02] Wide indicator asserted while the addressed location is 16-bit data.
// [R03] IDE host drives register address, one bank select, one strobe.
// [R04] IDE high bank reaches offsets 6-7; low bank reaches 0-7. Only the low bank is decoded here.
// [R05] Long-command ECC bytes move on the low data lane only.
// [R06] Independent I/O: drive decodes A0-3, host decodes A4-10.
// [R07] Upper select uses upper lane/odd register; lower uses low/even. Lower select alone here takes the register A0 gives.
// [R08] Independent memory: select pin high, drive decodes A0-10.
// [R09] Fixed I/O ranges: primary or secondary, drive decodes A0-9.
// [R10] Host writes zeros to unused bits; unused read bits are ignored.
// [R11] All block data passes through the 16-bit data register.
// [R12] Error flags valid only with status error; else diagnostic code.
// [R13] Error bits 7..0: bad block through address mark missing.
// [R14] Media change flags unsupported; unused error bits read zero.
// [R15] Old precompensation register now enables look-ahead reads.
// [R16] Sector count zero means 256 sectors.
// [R17] Sector count reads remaining sectors at completion.
// [R18] Sector number: start sector, or block address bits 0-7.
// [R19] Track low: cylinder low, or block address bits 8-15.
// [R20] Track high: cylinder high, or block address bits 16-23.
// [R21] Drive/head holds unit and head; head field is count minus one.
// [R22] Address-mode bit: 0 geometry, 1 linear block addressing.
// [R23] Data register auto-increments on each access.
// [R24] Memory window 400-7FF always presents the next data word.
// [R25] Unselected or idle: lines undriven, registers untouched.
`timescale 1ns/1ps
`include "athp_regs.vh"
module athp_port (
	input wire mclk_in,
	input wire rst_n_in,
	input wire ce_in,
	input wire [1:0] mode_in,
	input wire secondary_in,
	input wire [10:0] addr_in,
	input wire reg_n_in,
	input wire lower_lane_select_n_in,
	input wire upper_lane_select_n_in,
	input wire oe_n_in,
	input wire we_n_in,
	input wire host_read_strobe_n_in,
	input wire host_write_strobe_n_in,
	input wire [15:0] data_in,
	output wire [15:0] data_out,
	output wire [1:0] data_oe_out,
	output wire wide_transfer_indicator_n_out,
	input wire ecc_phase_in,
	input wire [15:0] buf_rd_word_in,
	output wire buf_rd_pop_out,
	output wire [15:0] buf_wr_word_out,
	output wire [1:0] buf_wr_be_out,
	output wire buf_wr_push_out,
	input wire done_in,
	input wire [7:0] done_sc_in,
	input wire [7:0] done_sn_in,
	input wire [7:0] done_cl_in,
	input wire [7:0] done_ch_in,
	input wire [7:0] done_dh_in,
	input wire err_load_in,
	input wire err_diag_in,
	input wire [7:0] err_code_in,
	output wire [7:0] lookahead_enable_out,
	output wire [8:0] sector_total_out,
	output wire [7:0] start_sector_index_out,
	output wire [7:0] track_index_low_out,
	output wire [7:0] track_index_high_out,
	output wire [7:0] unit_and_head_select_out,
	output wire lba_mode_out,
	output wire [4:0] head_count_out
);
	wire [`ATHP_PIN_W-1:0] pins_s;
	wire [10:0] a_s;
	wire reg_n_s, ce1_n_s, ce2_n_s, oe_n_s, we_n_s, rd_n_s, wr_n_s;
	wire [15:0] d_s;
	reg [15:0] data_out_q;
	reg [1:0] data_oe_q;
	reg wide_n_q;
	reg pop_q, push_q;
	reg [15:0] wr_word_q;
	reg [1:0] wr_be_q;
	reg [7:0] err_q, la_q, sc_q, sn_q, cl_q, ch_q, dh_q;
	reg [8:0] total_q;
	reg [4:0] heads_q;
	reg act_q, is_rd_q, is_data_q;
	reg [1:0] lane_q;
	reg [2:0] idx_lo_q, idx_hi_q;
	reg hit, is_data, rd_req, wr_req;
	reg [1:0] lane;
	reg [2:0] idx, idx_lo, idx_hi;
	reg [15:0] rd_val;
	wire act;
	wire start;
	wire stop;

	// Pins pass two flops before any decode
	athp_sync #(.W(`ATHP_PIN_W), .RST({11'h000, 7'h7f, 16'h0000})) u_pins (
		.mclk_in(mclk_in),
		.rst_n_in(rst_n_in),
		.ce_in(ce_in),
		.d_in({addr_in, reg_n_in, lower_lane_select_n_in,
			upper_lane_select_n_in, oe_n_in, we_n_in,
			host_read_strobe_n_in, host_write_strobe_n_in, data_in}),
		.q_out(pins_s)
	);
	assign a_s = pins_s[33:23];
	assign reg_n_s = pins_s[22];
	assign ce1_n_s = pins_s[21];
	assign ce2_n_s = pins_s[20];
	assign oe_n_s = pins_s[19];
	assign we_n_s = pins_s[18];
	assign rd_n_s = pins_s[17];
	assign wr_n_s = pins_s[16];
	assign d_s = pins_s[15:0];

	// Address decode per addressing mode
	always @* begin
		hit = 1'b0;
		is_data = 1'b0;
		idx = a_s[2:0];
		rd_req = 1'b0;
		wr_req = 1'b0;
		case (mode_in)
		`ATHP_MODE_IDE: begin
			// Low bank only; high bank offsets 6-7 are control regs
			rd_req = !rd_n_s; // [R03]
			wr_req = !wr_n_s;
			hit = !ce1_n_s; // [R04]
			is_data = (a_s[2:0] == `ATHP_IDX_DATA);
		end
		`ATHP_MODE_IO: begin
			rd_req = !rd_n_s;
			wr_req = !wr_n_s;
			// Drive sees only A0-3 [R06]
			hit = !reg_n_s && (!a_s[3] || a_s[3:1] == `ATHP_DUP_DATA);
			is_data = a_s[3] || (a_s[2:0] == `ATHP_IDX_DATA);
		end
		`ATHP_MODE_MEM: begin
			rd_req = !oe_n_s;
			wr_req = !we_n_s;
			// Upper half of the window is all data [R08] [R24]
			if (a_s[`ATHP_MEM_DATA_BIT]) begin
				hit = reg_n_s;
				is_data = 1'b1;
			end else begin
				hit = reg_n_s && (a_s[9:4] == 6'h00) &&
					(!a_s[3] || a_s[3:1] == `ATHP_DUP_DATA);
				is_data = a_s[3] || (a_s[2:0] == `ATHP_IDX_DATA);
			end
		end
		`ATHP_MODE_FIX: begin
			rd_req = !rd_n_s;
			wr_req = !wr_n_s;
			// Primary or secondary base on A3-9 [R09]
			hit = !reg_n_s && (a_s[9:3] ==
				(secondary_in ? `ATHP_FIX_SEC : `ATHP_FIX_PRI));
			is_data = (a_s[2:0] == `ATHP_IDX_DATA);
		end
		default: hit = 1'b0;
		endcase
		if (rd_req == wr_req)
			hit = 1'b0; // [R25]
		if (ce1_n_s && ce2_n_s)
			hit = 1'b0; // [R25]
	end

	// Byte lanes: IDE by register width; else upper select odd/high, lower select low (even only with both)
	always @* begin
		lane = 2'b00;
		idx_lo = idx;
		idx_hi = idx | 3'h1;
		if (mode_in == `ATHP_MODE_IDE) begin
			lane = is_data ? 2'b11 : 2'b01; // [R01]
		end else if (!ce1_n_s && !ce2_n_s) begin
			lane = 2'b11; // [R07]
			idx_lo = {idx[2:1], 1'b0};
		end else if (!ce2_n_s) begin
			lane = 2'b10; // [R07]
		end else begin
			lane = 2'b01;
		end
		if (is_data && ecc_phase_in)
			lane = lane & 2'b01; // [R05]
	end

	assign act = hit;
	assign start = act && !act_q;
	assign stop = !act && act_q;

	// Read value for both lanes of the decoded access
	always @* begin
		rd_val = 16'h0000; // Unused bytes read zero [R10]
		if (is_data) begin
			rd_val = buf_rd_word_in; // [R11]
		end else begin
			rd_val[7:0] = tf_byte(idx_lo);
			rd_val[15:8] = tf_byte(idx_hi);
		end
	end

	// Task-file byte read; status is served elsewhere
	function [7:0] tf_byte;
		input [2:0] i;
		begin
			case (i)
			`ATHP_IDX_ERR: tf_byte = err_q;
			`ATHP_IDX_SC: tf_byte = sc_q; // [R17]
			`ATHP_IDX_SN: tf_byte = sn_q;
			`ATHP_IDX_CL: tf_byte = cl_q;
			`ATHP_IDX_CH: tf_byte = ch_q;
			`ATHP_IDX_DH: tf_byte = dh_q;
			default: tf_byte = 8'h00;
			endcase
		end
	endfunction

	// Access tracking, lane drive and data word stream
	always @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			act_q <= 1'b0;
			is_rd_q <= 1'b0;
			is_data_q <= 1'b0;
			lane_q <= 2'b00;
			idx_lo_q <= 3'h0;
			idx_hi_q <= 3'h0;
			data_out_q <= 16'h0000;
			data_oe_q <= 2'b00;
			wide_n_q <= 1'b1;
			pop_q <= 1'b0;
			push_q <= 1'b0;
			wr_word_q <= 16'h0000;
			wr_be_q <= 2'b00;
		end else if (ce_in) begin
			act_q <= act;
			pop_q <= 1'b0;
			push_q <= 1'b0;
			// 16-bit indicator follows the decoded location
			wide_n_q <= !(hit && is_data && !ecc_phase_in); // [R02]
			if (start) begin
				is_rd_q <= rd_req;
				is_data_q <= is_data;
				lane_q <= lane;
				idx_lo_q <= idx_lo;
				idx_hi_q <= idx_hi;
				if (rd_req) begin
					data_out_q <= rd_val;
					data_oe_q <= lane;
				end
			end
			if (act && !is_rd_q && !start)
				wr_word_q <= d_s; // Track data while write held
			if (stop) begin
				data_oe_q <= 2'b00; // [R25]
				if (is_data_q) begin
					// Each finished data access steps the buffer [R23] [R24]
					pop_q <= is_rd_q;
					push_q <= !is_rd_q;
					wr_be_q <= lane_q;
				end
			end
		end
	end

	// Task-file registers: host writes at access end, engine at completion
	always @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			err_q <= `ATHP_RST_ERR;
			la_q <= `ATHP_RST_BYTE;
			sc_q <= `ATHP_RST_BYTE;
			sn_q <= `ATHP_RST_BYTE;
			cl_q <= `ATHP_RST_BYTE;
			ch_q <= `ATHP_RST_BYTE;
			dh_q <= `ATHP_RST_DH;
		end else if (ce_in) begin
			if (stop && !is_rd_q && !is_data_q) begin
				if (lane_q[0])
					tf_write(idx_lo_q, wr_word_q[7:0]);
				if (lane_q[1])
					tf_write(idx_hi_q, wr_word_q[15:8]);
			end
			// Completion values override a same-cycle host write
			if (done_in) begin
				sc_q <= done_sc_in; // [R17]
				sn_q <= done_sn_in; // [R18]
				cl_q <= done_cl_in; // [R19]
				ch_q <= done_ch_in; // [R20]
				dh_q <= done_dh_in; // [R21]
			end
			if (err_load_in) begin
				// Diagnostic code passes whole; flags lose media bits
				err_q <= err_diag_in ? err_code_in : // [R12]
					(err_code_in & `ATHP_ERR_USED_MASK); // [R13] [R14]
			end
		end
	end

	// Host byte write into one task register
	task tf_write;
		input [2:0] i;
		input [7:0] v;
		begin
			case (i)
			`ATHP_IDX_ERR: la_q <= v; // [R15]
			`ATHP_IDX_SC: sc_q <= v;
			`ATHP_IDX_SN: sn_q <= v; // [R18]
			`ATHP_IDX_CL: cl_q <= v; // [R19]
			`ATHP_IDX_CH: ch_q <= v; // [R20]
			`ATHP_IDX_DH: dh_q <= v; // [R21]
			default: la_q <= la_q;
			endcase
		end
	endtask

	// Derived values for the command engine
	always @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			total_q <= 9'h100;
			heads_q <= 5'h01;
		end else if (ce_in) begin
			total_q <= (sc_q == 8'h00) ? 9'h100 : {1'b0, sc_q}; // [R16]
			heads_q <= {1'b0, dh_q[`ATHP_DH_HEAD_MSB:0]} + 5'h01; // [R21]
		end
	end

	assign data_out = data_out_q;
	assign data_oe_out = data_oe_q;
	assign wide_transfer_indicator_n_out = wide_n_q;
	assign buf_rd_pop_out = pop_q;
	assign buf_wr_word_out = wr_word_q;
	assign buf_wr_be_out = wr_be_q;
	assign buf_wr_push_out = push_q;
	assign lookahead_enable_out = la_q;
	assign sector_total_out = total_q;
	assign start_sector_index_out = sn_q;
	assign track_index_low_out = cl_q;
	assign track_index_high_out = ch_q;
	assign unit_and_head_select_out = dh_q;
	assign lba_mode_out = dh_q[`ATHP_DH_LBA_BIT]; // [R22]
	assign head_count_out = heads_q;
endmodule // athp_port

// file: hdl/athp_regs.vh
// Task-file port constants: register indices, field positions, resets.
// Assumes inclusion by athp_port.v only; definitions only.
`ifndef ATHP_REGS_VH
`define ATHP_REGS_VH
// Addressing modes
`define ATHP_MODE_IDE 2'h0
`define ATHP_MODE_IO 2'h1
`define ATHP_MODE_MEM 2'h2
`define ATHP_MODE_FIX 2'h3
// Task-file register indices
`define ATHP_IDX_DATA 3'h0
`define ATHP_IDX_ERR 3'h1
`define ATHP_IDX_SC 3'h2
`define ATHP_IDX_SN 3'h3
`define ATHP_IDX_CL 3'h4
`define ATHP_IDX_CH 3'h5
`define ATHP_IDX_DH 3'h6
`define ATHP_IDX_STAT 3'h7
// Fixed address ranges, upper bits A9..A3
`define ATHP_FIX_PRI 7'h3e
`define ATHP_FIX_SEC 7'h2e
// Memory window for repeated data access
`define ATHP_MEM_DATA_BIT 4'ha
// Duplicate data pair in independent modes, A3..A1
`define ATHP_DUP_DATA 3'h4
// Error flag positions
`define ATHP_BAD_BLOCK_FLAG 7
`define ATHP_UNCORRECTABLE_FLAG 6
`define ATHP_MEDIA_CHANGED_FLAG 5
`define ATHP_SECTOR_ID_MISSING_FLAG 4
`define ATHP_MEDIA_CHANGE_REQUEST_FLAG 3
`define ATHP_COMMAND_ABORTED_FLAG 2
`define ATHP_TRACK_ZERO_MISSING_FLAG 1
`define ATHP_ADDRESS_MARK_MISSING_FLAG 0
`define ATHP_ERR_USED_MASK 8'hd7
// Drive/head fields
`define ATHP_DH_LBA_BIT 6
`define ATHP_DH_HEAD_MSB 3
// Reset values
`define ATHP_RST_BYTE 8'h00
`define ATHP_RST_DH 8'h00
`define ATHP_RST_ERR 8'h00
// Pin synchroniser width: addr 11, controls 7, data 16
`define ATHP_PIN_W 34
`endif

// file: hdl/athp_sync.v
// Two-flop synchroniser for a bus of asynchronous pins.
// Assumes each bit is a level; no bit is read before the second flop.
`timescale 1ns/1ps
module athp_sync #(
	parameter W = 8,
	parameter [W-1:0] RST = {W{1'b0}}
) (
	input wire mclk_in,
	input wire rst_n_in,
	input wire ce_in,
	input wire [W-1:0] d_in,
	output wire [W-1:0] q_out
);
	reg [W-1:0] meta_q;
	reg [W-1:0] sync_q;
	// First flop feeds only the second
	always @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			meta_q <= RST;
			sync_q <= RST;
		end else if (ce_in) begin
			meta_q <= d_in;
			sync_q <= meta_q;
		end
	end
	assign q_out = sync_q;
endmodule // athp_sync

// file: dv/athp_port_checker.sv
// Concurrent checks on the task-file port pins and task-register outputs.
// Assumes one mclk_in domain with rst_n_in as its asynchronous reset.
`timescale 1ns/1ps
module athp_port_checker (
	input wire mclk_in,
	input wire rst_n_in,
	input wire lower_lane_select_n_in,
	input wire upper_lane_select_n_in,
	input wire ecc_phase_in,
	input wire ce_in,
	input wire done_in,
	input wire [7:0] done_dh_in,
	input wire [1:0] data_oe_out,
	input wire wide_transfer_indicator_n_out,
	input wire buf_rd_pop_out,
	input wire buf_wr_push_out,
	input wire [8:0] sector_total_out,
	input wire [7:0] unit_and_head_select_out,
	input wire lba_mode_out,
	input wire [4:0] head_count_out
);
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!rst_n_in);
	// Pin-side and buffer-pulse behaviour
	chk_idle_undriven: assert property (
		(lower_lane_select_n_in && upper_lane_select_n_in) [*6] |-> data_oe_out == 2'h0)
		else $error("lanes driven while unselected");
	chk_ecc_narrow: assert property (
		ecc_phase_in [*3] |-> wide_transfer_indicator_n_out) else $error("wide during ecc");
	chk_pop_after_read: assert property (
		buf_rd_pop_out |-> $past(data_oe_out) != 2'h0) else $error("pop without read");
	chk_pop_pulse: assert property (
		buf_rd_pop_out |=> !buf_rd_pop_out) else $error("pop too long");
	chk_push_pulse: assert property (
		$rose(buf_wr_push_out) |=> $fell(buf_wr_push_out)) else $error("push too long");
	// Task-register derived outputs
	chk_total_range: assert property (
		sector_total_out != 9'h000 && sector_total_out <= 9'h100) else $error("bad total");
	chk_head_count: assert property (
		$stable(unit_and_head_select_out) ##1 $stable(unit_and_head_select_out)
		|-> head_count_out == {1'b0, unit_and_head_select_out[3:0]} + 5'h01)
		else $error("bad head count");
	chk_lba_bit: assert property (
		(done_in && ce_in) |=> unit_and_head_select_out == $past(done_dh_in)
		&& lba_mode_out == unit_and_head_select_out[6]) else $error("bad mode bit");
	cov_pop: cover property (buf_rd_pop_out);
	cov_push: cover property (buf_wr_push_out);
	cov_lba: cover property ($rose(lba_mode_out));
endmodule // athp_port_checker

bind athp_port athp_port_checker u_chk (.*);

// file: dv/athp_host.sv
// Host adapter model: one task-file access at a time on the card pins.
// Assumes the device answers within four clocks of the strobe edge.
`timescale 1ns/1ps
module athp_host (
	input wire mclk_in,
	input wire [1:0] mode_in,
	input wire [15:0] dev_data_in,
	input wire [1:0] dev_oe_in,
	output logic [10:0] addr_out,
	output logic reg_n_out,
	output logic lsel_n_out,
	output logic usel_n_out,
	output logic oe_n_out,
	output logic we_n_out,
	output logic rd_n_out,
	output logic wr_n_out,
	output logic [15:0] data_out
);
	// Pins idle at time zero
	initial begin
		{addr_out, reg_n_out, lsel_n_out, usel_n_out} = {11'h000, 3'b111};
		{oe_n_out, we_n_out, rd_n_out, wr_n_out} = 4'hf;
		data_out = 16'h5a5a;
	end
	// Strobe held seven clocks, then six idle; memory mode uses oe/we
	task automatic acc(input logic wr, input logic [10:0] a, input logic [1:0] sel,
		input logic [15:0] wd, output logic [15:0] rd, output logic [1:0] oe);
		rd = 16'h0000;
		oe = 2'h0;
		@(negedge mclk_in);
		{addr_out, reg_n_out, lsel_n_out, usel_n_out} = {a, mode_in == 2'h2, ~sel[0], ~sel[1]};
		{oe_n_out, we_n_out} = (mode_in == 2'h2) ? {wr, ~wr} : 2'b11;
		{rd_n_out, wr_n_out} = (mode_in == 2'h2) ? 2'b11 : {wr, ~wr};
		data_out = wr ? wd : ~data_out;
		repeat (7) begin
			@(negedge mclk_in);
			if (oe == 2'h0 && dev_oe_in != 2'h0) {rd, oe} = {dev_data_in, dev_oe_in};
		end
		{lsel_n_out, usel_n_out, oe_n_out, we_n_out, rd_n_out, wr_n_out} = 6'h3f;
		data_out = ~data_out; // Released lines do not keep the last value
		repeat (6) @(negedge mclk_in);
	endtask
endmodule // athp_host

// file: dv/tb_ata_taskfile_host_port.sv
// Testbench for the task-file port: host accesses in all four modes.
// Assumes athp_host drives the pins and the bench plays the command engine.
`timescale 1ns/1ps
module tb_ata_taskfile_host_port;
	logic mclk_in = 1'b0, rst_n_in = 1'b0, ce_in = 1'b1, secondary_in = 1'b0;
	logic [1:0] mode_in = 2'h0;
	logic reg_n_in, lower_lane_select_n_in, upper_lane_select_n_in, oe_n_in, we_n_in;
	logic host_read_strobe_n_in, host_write_strobe_n_in, wide_transfer_indicator_n_out;
	logic [10:0] addr_in;
	logic [15:0] data_in, data_out, buf_rd_word_in = 16'hc3a5, buf_wr_word_out, rd;
	logic [1:0] data_oe_out, buf_wr_be_out, oe;
	logic ecc_phase_in = 1'b0, buf_rd_pop_out, buf_wr_push_out, lba_mode_out, wide_seen;
	logic done_in = 1'b0, err_load_in = 1'b0, err_diag_in = 1'b0;
	logic [7:0] done_sc_in = 8'h03, done_sn_in = 8'h11, done_cl_in = 8'h22;
	logic [7:0] done_ch_in = 8'h33, done_dh_in = 8'h05, err_code_in = 8'hff;
	logic [7:0] lookahead_enable_out, start_sector_index_out, track_index_low_out;
	logic [7:0] track_index_high_out, unit_and_head_select_out;
	logic [8:0] sector_total_out;
	logic [4:0] head_count_out;
	logic [17:0] pushed;
	int error_cnt = 0, check_count = 0, pops = 0;
	athp_port u_dut (.*);
	athp_host u_host (.mclk_in(mclk_in), .mode_in(mode_in), .dev_data_in(data_out),
		.dev_oe_in(data_oe_out), .addr_out(addr_in), .reg_n_out(reg_n_in),
		.lsel_n_out(lower_lane_select_n_in), .usel_n_out(upper_lane_select_n_in),
		.oe_n_out(oe_n_in), .we_n_out(we_n_in), .rd_n_out(host_read_strobe_n_in),
		.wr_n_out(host_write_strobe_n_in), .data_out(data_in));
	initial forever #2 mclk_in = ~mclk_in;
	// Engine-side monitor of buffer pulses and the wide indicator
	always @(posedge mclk_in) begin
		if (buf_rd_pop_out === 1'b1) pops <= pops + 1;
		if (buf_wr_push_out === 1'b1) pushed <= {buf_wr_be_out, buf_wr_word_out};
		if (wide_transfer_indicator_n_out === 1'b0) wide_seen <= 1'b1;
	end
	task automatic check(input string name, input logic [17:0] seen, input logic [17:0] exp);
		check_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic go(input logic w, input logic [10:0] a, input logic [1:0] s,
		input logic [15:0] d);
		wide_seen = 1'b0;
		u_host.acc(w, a, s, d, rd, oe);
	endtask
	// One-cycle completion or error-load pulse from the engine
	task automatic fire(input logic e);
		@(negedge mclk_in) {done_in, err_load_in} = {~e, e};
		@(negedge mclk_in) {done_in, err_load_in} = 2'b00;
		repeat (3) @(negedge mclk_in);
	endtask
	task automatic summarize;
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge mclk_in);
		error_cnt++;
		summarize();
	end
	// Main sequence, IDE mode first
	initial begin
		repeat (6) @(negedge mclk_in);
		rst_n_in = 1'b1;
		repeat (4) @(negedge mclk_in);
		check("rst", {data_oe_out, sector_total_out, head_count_out}, 16'h2001);
		go(1'b1, 11'h002, 2'b01, 16'h0005);
		check("total", sector_total_out, 9'h005);
		go(1'b1, 11'h002, 2'b01, 16'h0000);
		check("total0", sector_total_out, 9'h100);
		go(1'b1, 11'h001, 2'b01, 16'h00aa);
		check("lookahead", lookahead_enable_out, 8'haa);
		go(1'b1, 11'h006, 2'b01, 16'h0043);
		check("dh", {lba_mode_out, head_count_out}, 6'h24);
		go(1'b0, 11'h006, 2'b01, 16'h0000);
		check("dh_rd", {oe, rd[7:0]}, 10'h143);
		go(1'b0, 11'h000, 2'b01, 16'h0000);
		check("data_rd", {oe, rd}, 18'h3c3a5);
		check("wide_pop", {wide_seen, pops[3:0]}, 5'h11);
		go(1'b1, 11'h000, 2'b01, 16'h1234);
		check("push", pushed, 18'h31234);
		go(1'b0, 11'h000, 2'b10, 16'h0000);
		check("high_bank", oe, 2'h0);
		ecc_phase_in = 1'b1;
		go(1'b0, 11'h000, 2'b01, 16'h0000);
		check("ecc", {wide_seen, oe}, 3'h1);
		ecc_phase_in = 1'b0;
		fire(1'b0);
		check("done", {start_sector_index_out, track_index_low_out}, 16'h1122);
		check("done2", {track_index_high_out, sector_total_out}, 17'h06603);
		check("done3", {lba_mode_out, head_count_out}, 6'h06);
		check("dh_out", unit_and_head_select_out, 8'h05);
		fire(1'b1);
		go(1'b0, 11'h001, 2'b01, 16'h0000);
		check("err", rd[7:0], 8'hd7);
		err_diag_in = 1'b1;
		fire(1'b1);
		go(1'b0, 11'h001, 2'b01, 16'h0000);
		check("diag", rd[7:0], 8'hff);
		mode_in = 2'h1;
		go(1'b0, 11'h7f3, 2'b10, 16'h0000);
		check("io_hi", {oe, rd[15:8]}, 10'h211);
		mode_in = 2'h3;
		go(1'b0, 11'h1f3, 2'b01, 16'h0000);
		check("pri", {oe, rd[7:0]}, 10'h111);
		secondary_in = 1'b1;
		go(1'b0, 11'h1f3, 2'b01, 16'h0000);
		check("pri_miss", oe, 2'h0);
		go(1'b0, 11'h173, 2'b01, 16'h0000);
		check("sec", {oe, rd[7:0]}, 10'h111);
		mode_in = 2'h2;
		go(1'b0, 11'h7ff, 2'b11, 16'h0000);
		check("mem_data", {oe, rd}, 18'h3c3a5);
		go(1'b1, 11'h002, 2'b01, 16'h0007);
		check("mem_wr", sector_total_out, 9'h007);
		summarize();
	end
endmodule // tb_ata_taskfile_host_port
